//--- rtl/mcr_top.sv
/*
  machine-check error reporting: feature and capability registers, global
  control, per-bank control/status/address, legacy type/address view and
  the check exception request.
  assumes a plain register port on core_clk and synchronous error inputs.
*/
// Function
// - legacy type and address appear in the bus-error bank status and address
// - legacy type and address registers stay readable by their own read
// - feature result reports arch support bit 14, exception support bit 7
// - capability count field gives bank count; banks 0..count-1 exist
// - check exception is delivered through vector 18
// - exceptions raised only while control register 4 bit 6 set
// - detected error writes 16-bit architectural code and sets valid flag
// - a 16-bit model code may be written into the same status
// - error meaning lies in the code, bank choice has no meaning
// - simple codes 0 none, 1 unclassified, 2 rom parity, 4 redundancy
// - bus init from another processor logs code 3
// - internal unclassified codes have upper six bits 000001
// - valid flag bit 63 set by hardware, cleared only by software
`timescale 1ns/10ps
`default_nettype none
module mcr_top
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // error detection
  input  wire logic                   err_valid,
  input  wire mcr_pkg::mcr_err_kind_e err_kind,
  input  wire logic [9:0]             err_detail,
  input  wire logic [15:0]            err_model,
  input  wire logic [31:0]            err_addr,
  input  wire logic                   err_addr_valid,
  // bus init pin from another processor
  input  wire logic                   bus_init_signal,
  // exception request
  output logic                        check_exception,
  output logic [7:0]                  check_exception_vector
);

  typedef struct packed {
    logic [1:0]  init_sync;
    logic        init_prev;
    logic [31:0] gctl_lo;
    logic [31:0] gctl_hi;
    logic        exc_en;
    logic [3:0]  bank_ctl;
    logic [3:0][31:0] st_lo;
    logic [3:0][31:0] st_hi;
    logic [3:0][31:0] baddr;
    logic [31:0] rdata;
    logic        exc;
    logic        exc_pend;
  } mcr_top_s;

  mcr_top_s st;
  mcr_top_s next_st;

  mcr_log_if log_bus ();

  logic                   enc_valid;
  mcr_pkg::mcr_err_kind_e enc_kind;

  // bus init edge takes precedence as an external error report
  always_comb
  begin
    enc_valid = err_valid | (st.init_sync[1] & ~st.init_prev);
    enc_kind  = err_kind;
    if (st.init_sync[1] & ~st.init_prev)
    begin
      enc_kind = mcr_pkg::MCR_ERR_EXT_INIT;
    end
  end

  mcr_encode u_encode
  (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .err_valid      (enc_valid),
    .err_kind       (enc_kind),
    .err_detail     (err_detail),
    .err_model      (err_model),
    .err_addr       (err_addr),
    .err_addr_valid (err_addr_valid),
    .rpt            (log_bus.enc)
  );

  function automatic logic is_bank_reg(input logic [7:0] a);
    is_bank_reg = (a >= mcr_pkg::REG_BANK_BASE) &&
                  (a < 8'(mcr_pkg::REG_BANK_BASE + 8'(4 * mcr_pkg::NUM_BANKS)));
  endfunction : is_bank_reg

  function automatic logic [1:0] bank_of(input logic [7:0] a);
    logic [7:0] off;
    off     = a - mcr_pkg::REG_BANK_BASE;
    bank_of = off[3:2];
  endfunction : bank_of

  logic [7:0] rd_off;
  logic [1:0] rd_bank;
  logic [1:0] wr_bank;
  logic [1:0] lb;
  logic       log_en;

  always_comb
  begin
    next_st           = st;
    rd_off            = reg_addr - mcr_pkg::REG_BANK_BASE;
    rd_bank           = bank_of(reg_addr);
    wr_bank           = bank_of(reg_addr);
    lb                = log_bus.bank;
    next_st.init_sync = {st.init_sync[0], bus_init_signal};
    next_st.init_prev = st.init_sync[1];

    // software writes
    if (reg_wr)
    begin
      case (reg_addr)
        mcr_pkg::REG_GCTL_LO: next_st.gctl_lo = reg_wdata;
        mcr_pkg::REG_GCTL_HI: next_st.gctl_hi = reg_wdata;
        mcr_pkg::REG_CR4:     next_st.exc_en  = reg_wdata[mcr_pkg::CR4_EXC_EN_BIT];
        default:
        begin
          if (is_bank_reg(reg_addr))
          begin
            case (rd_off[1:0])
              2'h0:    next_st.bank_ctl[wr_bank] = reg_wdata[0];
              2'h1:    next_st.st_lo[wr_bank]    = reg_wdata;
              2'h2:    next_st.st_hi[wr_bank]    = reg_wdata;
              default: next_st.baddr[wr_bank]    = reg_wdata;
            endcase
          end
        end
      endcase
    end

    // hardware logging; set wins over a same-cycle software clear
    log_en = log_bus.valid && st.bank_ctl[lb] && (st.gctl_lo[lb] != 1'b0);
    if (log_en)
    begin
      if (st.st_hi[lb][mcr_pkg::ST_HI_VALID_BIT])
      begin
        next_st.st_hi[lb][mcr_pkg::ST_HI_OVER_BIT] = 1'b1;
      end
      else
      begin
        next_st.st_lo[lb] = {log_bus.model_code, log_bus.arch_code};
        next_st.st_hi[lb][mcr_pkg::ST_HI_ADDRV_BIT] = log_bus.addr_valid;
        next_st.baddr[lb] = log_bus.addr;
      end
      next_st.st_hi[lb][mcr_pkg::ST_HI_VALID_BIT] = 1'b1;
      next_st.exc_pend = 1'b1;
    end

    // exception request: one pulse per logged error, only when enabled
    next_st.exc = st.exc_pend && st.exc_en;
    if (st.exc_pend)
    begin
      next_st.exc_pend = log_en;
    end

    // read data, valid the cycle after the strobe
    next_st.rdata = mcr_pkg::RESET_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        mcr_pkg::REG_FEATURE_LO:
        begin
          next_st.rdata[mcr_pkg::FEAT_ARCH_BIT] = 1'b1;
          next_st.rdata[mcr_pkg::FEAT_EXC_BIT]  = 1'b1;
        end
        mcr_pkg::REG_CAP_LO:
        begin
          next_st.rdata[7:0] = mcr_pkg::BANK_COUNT;
          next_st.rdata[mcr_pkg::CAP_CTL_P_BIT] = 1'b1;
        end
        mcr_pkg::REG_GCTL_LO:    next_st.rdata = st.gctl_lo;
        mcr_pkg::REG_GCTL_HI:    next_st.rdata = st.gctl_hi;
        mcr_pkg::REG_CR4:        next_st.rdata[mcr_pkg::CR4_EXC_EN_BIT] = st.exc_en;
        mcr_pkg::REG_LEG_TYPE:   next_st.rdata = st.st_lo[mcr_pkg::BUS_BANK];
        mcr_pkg::REG_LEG_ADDR:   next_st.rdata = st.baddr[mcr_pkg::BUS_BANK];
        mcr_pkg::REG_EXC_STATUS: next_st.rdata = {23'h0, st.exc_pend, mcr_pkg::EXC_VECTOR};
        default:
        begin
          if (is_bank_reg(reg_addr))
          begin
            case (rd_off[1:0])
              2'h0:    next_st.rdata[0] = st.bank_ctl[rd_bank];
              2'h1:    next_st.rdata    = st.st_lo[rd_bank];
              2'h2:    next_st.rdata    = st.st_hi[rd_bank];
              default: next_st.rdata    = st.baddr[rd_bank];
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata              = st.rdata;
  assign check_exception        = st.exc;
  assign check_exception_vector = mcr_pkg::EXC_VECTOR;

endmodule : mcr_top
`default_nettype wire

//--- rtl/mcr_pkg.sv
/*
  package for the machine-check error reporting block: register indices,
  field positions, reset values and error code encodings.
  assumes a single core clock domain and a plain register port.
*/
`default_nettype none
package mcr_pkg;

  // register indices on the plain port
  localparam logic [7:0] REG_FEATURE_LO   = 8'h00;
  localparam logic [7:0] REG_CAP_LO       = 8'h01;
  localparam logic [7:0] REG_GCTL_LO      = 8'h02;
  localparam logic [7:0] REG_GCTL_HI      = 8'h03;
  localparam logic [7:0] REG_CR4          = 8'h04;
  localparam logic [7:0] REG_LEG_TYPE     = 8'h05;
  localparam logic [7:0] REG_LEG_ADDR     = 8'h06;
  localparam logic [7:0] REG_EXC_STATUS   = 8'h07;
  // bank registers: base + bank*4 + {0 ctl, 1 status lo, 2 status hi, 3 addr}
  localparam logic [7:0] REG_BANK_BASE    = 8'h10;

  localparam int         NUM_BANKS        = 4;
  localparam int         BUS_BANK         = 0;
  localparam logic [7:0] BANK_COUNT       = 8'h04;

  // feature result bits
  localparam int         FEAT_ARCH_BIT    = 14;
  localparam int         FEAT_EXC_BIT     = 7;
  // capability: count in [7:0], control present at bit 8
  localparam int         CAP_CTL_P_BIT    = 8;
  // exception enable in control register 4
  localparam int         CR4_EXC_EN_BIT   = 6;
  localparam logic [7:0] EXC_VECTOR       = 8'h12;

  // status high word bits (upper half of the 64-bit status)
  localparam int         ST_HI_VALID_BIT  = 31;
  localparam int         ST_HI_OVER_BIT   = 30;
  localparam int         ST_HI_ADDRV_BIT  = 26;

  // architectural error codes
  localparam logic [15:0] CODE_NONE       = 16'h0000;
  localparam logic [15:0] CODE_UNCLASS    = 16'h0001;
  localparam logic [15:0] CODE_UROM_PAR   = 16'h0002;
  localparam logic [15:0] CODE_EXT_BUS_INIT_SIGNAL  = 16'h0003;
  localparam logic [15:0] CODE_REDUND     = 16'h0004;
  localparam logic [5:0]  CODE_INT_PREFIX = 6'h01;

  typedef enum logic [2:0] {
    MCR_ERR_UNCLASS,
    MCR_ERR_UROM_PAR,
    MCR_ERR_EXT_INIT,
    MCR_ERR_REDUND,
    MCR_ERR_INTERNAL
  } mcr_err_kind_e;

  localparam logic [31:0] RESET_ZERO      = 32'h0000_0000;

endpackage : mcr_pkg
`default_nettype wire

//--- rtl/mcr_log_if.sv
/*
  interface carrying one error report from the encoder to the bank logic.
  assumes both ends run on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface mcr_log_if;
  logic        valid;
  logic [1:0]  bank;
  logic [15:0] arch_code;
  logic [15:0] model_code;
  logic [31:0] addr;
  logic        addr_valid;
  modport enc
  (
    output valid,
    output bank,
    output arch_code,
    output model_code,
    output addr,
    output addr_valid
  );
  modport bnk
  (
    input  valid,
    input  bank,
    input  arch_code,
    input  model_code,
    input  addr,
    input  addr_valid
  );
endinterface : mcr_log_if
`default_nettype wire

//--- rtl/mcr_encode.sv
/*
  registered error encoder: turns one detected error into an
  architectural code, a model code and a chosen bank.
  assumes error inputs are already synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module mcr_encode
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // detected error
  input  wire logic                  err_valid,
  input  wire mcr_pkg::mcr_err_kind_e err_kind,
  input  wire logic [9:0]            err_detail,
  input  wire logic [15:0]           err_model,
  input  wire logic [31:0]           err_addr,
  input  wire logic                  err_addr_valid,
  // report out
  mcr_log_if.enc                     rpt
);

  typedef struct packed {
    logic        valid;
    logic [1:0]  bank;
    logic [15:0] arch_code;
    logic [15:0] model_code;
    logic [31:0] addr;
    logic        addr_valid;
  } mcr_enc_s;

  mcr_enc_s st;
  mcr_enc_s next_st;

  always_comb
  begin
    next_st            = st;
    next_st.valid      = err_valid;
    next_st.model_code = err_model;
    next_st.addr       = err_addr;
    next_st.addr_valid = err_addr_valid;
    // bank choice is model specific; the code alone carries the meaning
    next_st.bank       = 2'(mcr_pkg::BUS_BANK);
    case (err_kind)
      mcr_pkg::MCR_ERR_UNCLASS:  next_st.arch_code = mcr_pkg::CODE_UNCLASS;
      mcr_pkg::MCR_ERR_UROM_PAR: next_st.arch_code = mcr_pkg::CODE_UROM_PAR;
      mcr_pkg::MCR_ERR_EXT_INIT: next_st.arch_code = mcr_pkg::CODE_EXT_BUS_INIT_SIGNAL;
      mcr_pkg::MCR_ERR_REDUND:   next_st.arch_code = mcr_pkg::CODE_REDUND;
      mcr_pkg::MCR_ERR_INTERNAL: next_st.arch_code = {mcr_pkg::CODE_INT_PREFIX, err_detail};
      default:                   next_st.arch_code = mcr_pkg::CODE_UNCLASS;
    endcase
    if (err_kind == mcr_pkg::MCR_ERR_INTERNAL)
    begin
      next_st.bank = 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rpt.valid      = st.valid;
  assign rpt.bank       = st.bank;
  assign rpt.arch_code  = st.arch_code;
  assign rpt.model_code = st.model_code;
  assign rpt.addr       = st.addr;
  assign rpt.addr_valid = st.addr_valid;

endmodule : mcr_encode
`default_nettype wire

//--- testbench/mcr_top_assertions.sv
/*
  port checker for mcr_top: register read path, exception pulse and gating.
  assumes a single core_clk domain, bound to every mcr_top instance.
*/
`timescale 1ns/10ps
`default_nettype none
module mcr_top_chk
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // exception request
  input wire logic        check_exception,
  input wire logic [7:0]  check_exception_vector
);
  logic cr4_en;

  // shadow of the exception enable bit, from observed writes
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      cr4_en <= 1'b0;
    else if (reg_wr && reg_addr == mcr_pkg::REG_CR4)
      cr4_en <= reg_wdata[mcr_pkg::CR4_EXC_EN_BIT];

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  vector_const_a: assert property (check_exception_vector == 8'h12)
    else $error("exception vector wrong");
  exc_gated_a: assert property (check_exception |-> $past(cr4_en))
    else $error("exception while disabled");
  exc_pulse_a: assert property (check_exception |=> !check_exception)
    else $error("exception longer than one cycle");
  feat_bits_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[14] && reg_rdata[7])
    else $error("feature bits missing");
  bank_count_a: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata[7:0] == 8'h04)
    else $error("bank count wrong");
  vec_read_a: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata[7:0] == 8'h12)
    else $error("vector readback wrong");
  cr4_read_a: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[6] == cr4_en)
    else $error("enable readback wrong");
  no_bank_a: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0000_0000)
    else $error("absent bank not zero");
  idle_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule : mcr_top_chk

bind mcr_top mcr_top_chk u_chk
(
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .check_exception(check_exception), .check_exception_vector(check_exception_vector)
);
`default_nettype wire

//--- testbench/mcr_top_tb_top.sv
/*
  testbench for mcr_top: register reads and writes, error injection.
  assumes the checker is bound separately, 25 MHz core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module mcr_top_tb_top;
  logic                   core_clk, rst_n, reg_wr, reg_rd;
  logic                   err_valid, err_addr_valid, bus_init_signal, check_exception;
  logic [7:0]             reg_addr, check_exception_vector, ba;
  logic [31:0]            reg_wdata, reg_rdata, err_addr, d, lo;
  logic [9:0]             err_detail;
  logic [15:0]            err_model;
  logic [15:0]            codes [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h06a5};
  mcr_pkg::mcr_err_kind_e err_kind;
  int                     mismatches = 0;
  int                     num_checks = 0;
  int                     exc_cnt = 0;

  mcr_top uut
  (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_valid(err_valid),
    .err_kind(err_kind), .err_detail(err_detail), .err_model(err_model), .err_addr(err_addr),
    .err_addr_valid(err_addr_valid), .bus_init_signal(bus_init_signal),
    .check_exception(check_exception), .check_exception_vector(check_exception_vector)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (check_exception === 1'b1)
      exc_cnt++;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask : rd

  task automatic inject(input int k, input logic [15:0] m, input logic [31:0] a);
    @(posedge core_clk);
    err_valid <= 1'b1;
    err_kind <= mcr_pkg::mcr_err_kind_e'(k);
    err_model <= m;
    err_addr <= a;
    @(posedge core_clk);
    err_valid <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : inject

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    {reg_wr, reg_rd, err_valid, bus_init_signal, rst_n} = '0;
    {reg_addr, reg_wdata, err_addr, err_model} = '0;
    err_addr_valid = 1'b1;
    err_detail = 10'h2a5;
    err_kind = mcr_pkg::MCR_ERR_UNCLASS;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(mcr_pkg::REG_FEATURE_LO, d);
    chk("feature", d, 32'h0000_4080);
    rd(mcr_pkg::REG_CAP_LO, d);
    chk("capability", d & 32'h1ff, 32'h0000_0104);
    rd(mcr_pkg::REG_EXC_STATUS, d);
    chk("vector", d & 32'hff, 32'h0000_0012);
    rd(8'h20, d);
    chk("absent bank", d, 32'h0000_0000);
    $display("test identity done");
    wr(mcr_pkg::REG_GCTL_LO, 32'hffff_ffff);
    wr(mcr_pkg::REG_GCTL_HI, 32'hffff_ffff);
    for (int i = 0; i < 4; i++)
    begin
      ba = mcr_pkg::REG_BANK_BASE + 8'(4 * i);
      wr(ba, 32'h0000_0001);
      wr(ba + 8'h01, 32'h0000_0000);
      wr(ba + 8'h02, 32'h0000_0000);
      rd(ba + 8'h02, d);
      chk("status hi", d, 32'h0000_0000);
    end
    $display("test bring-up done");
    inject(1, 16'h0000, 32'h0000_0000);
    chk("exception off", 32'(exc_cnt), 32'h0000_0000);
    wr(mcr_pkg::REG_CR4, 32'h0000_0040);
    repeat (4) @(posedge core_clk);
    chk("exception not deferred", 32'(exc_cnt), 32'h0000_0000);
    rd(mcr_pkg::REG_CR4, d);
    chk("enable readback", d, 32'h0000_0040);
    $display("test enable done");
    for (int i = 0; i < 5; i++)
    begin
      ba = mcr_pkg::REG_BANK_BASE + ((i == 4) ? 8'h04 : 8'h00);
      wr(mcr_pkg::REG_BANK_BASE + 8'h01, 32'h0000_0000);
      wr(mcr_pkg::REG_BANK_BASE + 8'h02, 32'h0000_0000);
      inject(i, 16'h5a00 + 16'(i), 32'h1000_0000 + 32'(i));
      chk("exception count", 32'(exc_cnt), 32'(1 + i));
      lo = {16'h5a00 + 16'(i), codes[i]};
      rd(ba + 8'h02, d);
      chk("valid", d & 32'h8400_0000, 32'h8400_0000);
      rd(ba + 8'h01, d);
      chk("status lo", d, lo);
      rd(ba + 8'h03, d);
      chk("address", d, 32'h1000_0000 + 32'(i));
      if (i < 4)
      begin
        rd(mcr_pkg::REG_LEG_TYPE, d);
        chk("legacy type", d, lo);
        rd(mcr_pkg::REG_LEG_ADDR, d);
        chk("legacy address", d, 32'h1000_0000 + 32'(i));
      end
      wr(ba + 8'h02, 32'h0000_0000);
      rd(ba + 8'h02, d);
      chk("cleared", d, 32'h0000_0000);
    end
    $display("test codes done");
    wr(mcr_pkg::REG_BANK_BASE + 8'h01, 32'h0000_0000);
    @(posedge core_clk);
    bus_init_signal <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus_init_signal <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(mcr_pkg::REG_BANK_BASE + 8'h01, d);
    chk("bus init code", d & 32'hffff, 32'h0000_0003);
    rd(mcr_pkg::REG_BANK_BASE + 8'h02, d);
    chk("bus init valid", d & 32'h8000_0000, 32'h8000_0000);
    $display("test bus init done");
    // soft reset, then family 6 style bring-up with bank zero left off
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    wr(mcr_pkg::REG_GCTL_LO, 32'hffff_ffff);
    wr(mcr_pkg::REG_GCTL_HI, 32'hffff_ffff);
    for (int i = 1; i < 4; i++)
      wr(mcr_pkg::REG_BANK_BASE + 8'(4 * i), 32'h0000_0001);
    for (int i = 0; i < 4; i++)
      wr(mcr_pkg::REG_BANK_BASE + 8'(4 * i) + 8'h02, 32'h0000_0000);
    rd(mcr_pkg::REG_BANK_BASE, d);
    chk("bank zero control", d, 32'h0000_0000);
    rd(mcr_pkg::REG_CR4, d);
    chk("enable after reset", d, 32'h0000_0000);
    lo = 32'(exc_cnt);
    inject(1, 16'h0000, 32'h0000_0000);
    rd(mcr_pkg::REG_BANK_BASE + 8'h02, d);
    chk("disabled bank", d, 32'h0000_0000);
    inject(4, 16'h0011, 32'h0000_2000);
    inject(4, 16'h0022, 32'h0000_3000);
    rd(mcr_pkg::REG_BANK_BASE + 8'h06, d);
    chk("overflow", d & 32'hc400_0000, 32'hc400_0000);
    rd(mcr_pkg::REG_BANK_BASE + 8'h05, d);
    chk("first code kept", d, 32'h0011_06a5);
    rd(mcr_pkg::REG_BANK_BASE + 8'h07, d);
    chk("first address kept", d, 32'h0000_2000);
    chk("exception gated", 32'(exc_cnt), lo);
    $display("test soft reset done");
    report_and_stop();
  end
endmodule : mcr_top_tb_top
`default_nettype wire
